// >>> design/sbct_count_source.sv
// Count source: prescaler, pin synchronisers and tick generation
module sbct_count_source #(
	parameter int PRESC_W = 5
) (
	input  wire logic core_clk_i,
	input  wire logic reset_n_i,
	input  wire logic event_input_pin_i,
	input  wire logic event_rising_edge_i,
	input  wire logic subclock_i,
	input  wire logic low_power_mode_i,
	sbct_tick_if.src  tick
);
	// =====================================================
	// Elaboration check
	if (PRESC_W < 5) begin : g_bad_presc
		$error("sbct_count_source: PRESC_W must be at least 5");
	end

	// =====================================================
	// Pin synchronisers, three stages, change taken when stages 2 and 3 agree
	logic [2:0] evt_sync_q;
	logic [2:0] sub_sync_q;
	logic       evt_lvl_q;
	logic       sub_lvl_q;
	logic [PRESC_W-1:0] presc_q;
	logic [1:0] sub_div_q;

	wire evt_lvl_d = (evt_sync_q[1] == evt_sync_q[2]) ? evt_sync_q[2] : evt_lvl_q;
	wire sub_lvl_d = (sub_sync_q[1] == sub_sync_q[2]) ? sub_sync_q[2] : sub_lvl_q;
	wire evt_edge  = (evt_lvl_d != evt_lvl_q) && (evt_lvl_d == event_rising_edge_i);
	wire sub_rise  = sub_lvl_d && !sub_lvl_q;
	// Resynchronised quarter subclock, up to one system period of jitter
	wire sub_qtr   = sub_rise && (sub_div_q == sbct_pkg::SUB_QTR_LAST);

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			evt_sync_q <= '0;
			sub_sync_q <= '0;
			evt_lvl_q  <= 1'b0;
			sub_lvl_q  <= 1'b0;
			presc_q    <= '0;
			sub_div_q  <= '0;
		end else begin
			evt_sync_q <= {evt_sync_q[1:0], event_input_pin_i};
			sub_sync_q <= {sub_sync_q[1:0], subclock_i};
			evt_lvl_q  <= evt_lvl_d;
			sub_lvl_q  <= sub_lvl_d;
			presc_q    <= presc_q + 1'b1;
			sub_div_q  <= sub_rise ? sub_div_q + 1'b1 : sub_div_q;
		end
	end

	// =====================================================
	// Prescaler taps, one-cycle enables
	wire div32 = (presc_q[4:0] == 5'h1F);
	wire div16 = (presc_q[3:0] == 4'hF);
	wire div4  = (presc_q[1:0] == 2'h3);

	function automatic logic pick(input logic [2:0] sel, input logic alt, input logic lp);
		logic t;
		t = 1'b0;
		unique case (sel)
			sbct_pkg::SEL_DIV32:   t = div32;
			sbct_pkg::SEL_DIV16:   t = div16;
			sbct_pkg::SEL_DIV4:    t = div4;
			sbct_pkg::SEL_SUB_QTR: t = sub_qtr;
			default:               t = alt;
		endcase
		// Only the quarter subclock runs in the low-power modes
		if (lp && sel != sbct_pkg::SEL_SUB_QTR) begin
			t = 1'b0;
		end
		return t;
	endfunction : pick

	// Each source becomes a single-cycle enable in the system domain
	assign tick.lower_tick = pick(tick.lower_sel, evt_edge, low_power_mode_i);
	assign tick.upper_tick = pick(tick.upper_sel, 1'b0, low_power_mode_i);
endmodule : sbct_count_source

// >>> design/sbct_pkg.sv
// Constants shared by the compare timer and its count source
package sbct_pkg;
	// =====================================================
	// Register offsets on the 8-bit CPU bus
	localparam logic [2:0] OFF_CONTROL     = 3'h0;
	localparam logic [2:0] OFF_STATUS      = 3'h1;
	localparam logic [2:0] OFF_COUNT_HI    = 3'h2;
	localparam logic [2:0] OFF_COUNT_LO    = 3'h3;
	localparam logic [2:0] OFF_COMPARE_HI  = 3'h4;
	localparam logic [2:0] OFF_COMPARE_LO  = 3'h5;
	localparam logic [2:0] OFF_IRQ_ENABLE  = 3'h6;
	localparam logic [2:0] OFF_IRQ_REQUEST = 3'h7;

	// =====================================================
	// timer_control fields
	localparam int CTL_HIGH_LEVEL_BIT = 7;
	localparam int CTL_UPPER_SEL_MSB  = 6;
	localparam int CTL_UPPER_SEL_LSB  = 4;
	localparam int CTL_LOW_LEVEL_BIT  = 3;
	localparam int CTL_LOWER_SEL_MSB  = 2;
	localparam int CTL_LOWER_SEL_LSB  = 0;
	localparam int CTL_SPLIT_BIT      = 6;

	// =====================================================
	// timer_control_status fields
	localparam int ST_HIGH_OVF_BIT  = 7;
	localparam int ST_HIGH_CMP_BIT  = 6;
	localparam int ST_HIGH_OVIE_BIT = 5;
	localparam int ST_HIGH_CCLR_BIT = 4;
	localparam int ST_LOW_OVF_BIT   = 3;
	localparam int ST_LOW_CMP_BIT   = 2;
	localparam int ST_LOW_OVIE_BIT  = 1;
	localparam int ST_LOW_CCLR_BIT  = 0;

	// Request and enable bits share positions
	localparam int IRQ_HIGH_BIT = 3;
	localparam int IRQ_LOW_BIT  = 2;

	// =====================================================
	// Reset values
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;
	localparam logic [7:0]  BYTE_ALL_ONES = 8'hFF;

	// =====================================================
	// Clock select codes
	localparam logic [2:0] SEL_DIV32    = 3'h4;
	localparam logic [2:0] SEL_DIV16    = 3'h5;
	localparam logic [2:0] SEL_DIV4     = 3'h6;
	localparam logic [2:0] SEL_SUB_QTR  = 3'h7;
	localparam int         SEL_INT_BIT  = 2;
	localparam logic [1:0] SUB_QTR_LAST = 2'h3;
endpackage : sbct_pkg

// >>> design/sbct_tick_if.sv
// Clock-select and count-enable signals between timer core and count source
interface sbct_tick_if;
	logic [2:0] lower_sel;
	logic [2:0] upper_sel;
	logic       lower_tick;
	logic       upper_tick;

	modport src (input lower_sel, input upper_sel, output lower_tick, output upper_tick);
	modport dst (output lower_sel, output upper_sel, input lower_tick, input upper_tick);
endinterface : sbct_tick_if

// >>> design/sbct_timer.sv
// Compare timer core: counter, compare, flags, byte staging and toggle pins

// Functional notes
// - High request on full/upper match or overflow
// - Writing one clears set high request
// - Low request on split lower match or on any lower-byte overflow, split or cascade; write-one clears
// - Enable bits gate each half's interrupt
// - Event pin edge can clock lower counter
// - Select 111 uses subclock divided by four
// - 16-bit accesses except compare reads pass byte staging register
// - Upper write staged, lower write commits both
// - Upper counter read latches lower into staging
// - Compare reads come straight from register
// - Full match toggles pin; control write wins
// - Compare-low write: coincident match uses the written value
// - Matches only on count enable; split upper half uses upper enable
// - Full match sets high flag; lower sets low
// - Overflow flags; counter-low write suppresses overflow, counter-high write for split upper
// - Quarter subclock resynchronised into system clock
// - Reset values: count 0, compare FFFF, controls 0
// - Upper select bit2 splits into two halves
// - Full match sets flag, optionally clears counter
// - Wrap sets overflow; request needs overflow enable
// - Low-power modes count only quarter subclock
module sbct_timer (
	input  wire logic       core_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic [2:0] bus_addr_i,
	input  wire logic       bus_wr_i,
	input  wire logic       bus_rd_i,
	input  wire logic [7:0] bus_wdata_i,
	output logic      [7:0] bus_rdata_o,
	input  wire logic       event_input_pin_i,
	input  wire logic       event_rising_edge_i,
	input  wire logic       subclock_i,
	input  wire logic       low_power_mode_i,
	output logic            high_toggle_pin_o,
	output logic            low_toggle_pin_o,
	output logic            high_irq_o,
	output logic            low_irq_o
);
	// =====================================================
	// State
	logic [7:0]  ctrl_q;
	logic [7:0]  status_q;
	logic [15:0] count_q;
	logic [15:0] compare_q;
	logic [7:0]  stage_q;
	logic [3:0]  irq_en_q;
	logic [3:0]  irq_req_q;
	logic        pin_hi_q;
	logic        pin_lo_q;
	logic [7:0]  rdata_q;

	// =====================================================
	// Count source
	sbct_tick_if tick_bus ();

	assign tick_bus.lower_sel = ctrl_q[sbct_pkg::CTL_LOWER_SEL_MSB:sbct_pkg::CTL_LOWER_SEL_LSB];
	assign tick_bus.upper_sel = ctrl_q[sbct_pkg::CTL_UPPER_SEL_MSB:sbct_pkg::CTL_UPPER_SEL_LSB];

	sbct_count_source #(
		.PRESC_W (5)
	) u_source (
		.core_clk_i          (core_clk_i),
		.reset_n_i           (reset_n_i),
		.event_input_pin_i   (event_input_pin_i),
		.event_rising_edge_i (event_rising_edge_i),
		.subclock_i          (subclock_i),
		.low_power_mode_i    (low_power_mode_i),
		.tick                (tick_bus)
	);

	// =====================================================
	// Bus decode
	wire wr_ctrl  = bus_wr_i && (bus_addr_i == sbct_pkg::OFF_CONTROL);
	wire wr_stat  = bus_wr_i && (bus_addr_i == sbct_pkg::OFF_STATUS);
	wire wr_ch    = bus_wr_i && (bus_addr_i == sbct_pkg::OFF_COUNT_HI);
	wire wr_cl    = bus_wr_i && (bus_addr_i == sbct_pkg::OFF_COUNT_LO);
	wire wr_oh    = bus_wr_i && (bus_addr_i == sbct_pkg::OFF_COMPARE_HI);
	wire wr_ol    = bus_wr_i && (bus_addr_i == sbct_pkg::OFF_COMPARE_LO);
	wire wr_ien   = bus_wr_i && (bus_addr_i == sbct_pkg::OFF_IRQ_ENABLE);
	wire wr_ireq  = bus_wr_i && (bus_addr_i == sbct_pkg::OFF_IRQ_REQUEST);
	wire rd_ch    = bus_rd_i && !bus_wr_i && (bus_addr_i == sbct_pkg::OFF_COUNT_HI);

	wire       split   = ctrl_q[sbct_pkg::CTL_SPLIT_BIT];
	wire       cclr_h  = status_q[sbct_pkg::ST_HIGH_CCLR_BIT];
	wire       cclr_l  = status_q[sbct_pkg::ST_LOW_CCLR_BIT];
	wire       ovie_h  = status_q[sbct_pkg::ST_HIGH_OVIE_BIT];
	wire       ovie_l  = status_q[sbct_pkg::ST_LOW_OVIE_BIT];
	wire [7:0] cnt_hi  = count_q[15:8];
	wire [7:0] cnt_lo  = count_q[7:0];

	// =====================================================
	// Count enables
	wire tick_lo = tick_bus.lower_tick;
	// Cascaded upper half follows the lower count enable
	wire tick_hi = split ? tick_bus.upper_tick : tick_bus.lower_tick;

	// =====================================================
	// Compare against the value being written, so a coincident low write
	// drops the old match but still hits when the new value equals the count
	wire [15:0] cmp_wr_full = split ? {compare_q[15:8], bus_wdata_i} : {stage_q, bus_wdata_i};
	wire [15:0] cmp_eff     = wr_ol ? cmp_wr_full : compare_q;

	wire match_full = !split && tick_lo && (count_q == cmp_eff);
	wire match_lo   = tick_lo && (cnt_lo == cmp_eff[7:0]);
	wire match_up   = split && tick_hi && (cnt_hi == cmp_eff[15:8]);
	wire match_h    = match_full || match_up;
	wire match_l    = split && match_lo;

	wire clr_full = match_full && cclr_h;
	wire clr_up   = match_up && cclr_h;
	wire clr_lo8  = match_l && cclr_l;
	wire clr_lo   = clr_full || clr_lo8;

	wire lo_wrap   = tick_lo && (cnt_lo == sbct_pkg::BYTE_ALL_ONES);
	wire ovf_lo    = lo_wrap && !clr_lo && !wr_cl;
	wire ovf_full  = !split && lo_wrap && (cnt_hi == sbct_pkg::BYTE_ALL_ONES) && !clr_full && !wr_cl;
	wire ovf_up    = split && tick_hi && (cnt_hi == sbct_pkg::BYTE_ALL_ONES) && !clr_up && !wr_ch;
	wire ovf_h     = ovf_full || ovf_up;

	// =====================================================
	// Counter next value
	wire [7:0] lo_inc = cnt_lo + 8'h01;
	wire [7:0] hi_inc = cnt_hi + 8'h01;

	wire [7:0] lo_d = wr_cl  ? bus_wdata_i :
	                  clr_lo ? sbct_pkg::BYTE_ZERO :
	                  tick_lo ? lo_inc : cnt_lo;

	// In cascade the upper byte only takes data when the low write commits
	wire [7:0] hi_cas_d = wr_cl    ? stage_q :
	                      clr_full ? sbct_pkg::BYTE_ZERO :
	                      lo_wrap  ? hi_inc : cnt_hi;
	wire [7:0] hi_spl_d = wr_ch    ? bus_wdata_i :
	                      clr_up   ? sbct_pkg::BYTE_ZERO :
	                      tick_hi  ? hi_inc : cnt_hi;
	wire [15:0] count_d = {split ? hi_spl_d : hi_cas_d, lo_d};

	// =====================================================
	// Compare next value
	wire [7:0] cmp_hi_d = (split && wr_oh) ? bus_wdata_i :
	                      (!split && wr_ol) ? stage_q : compare_q[15:8];
	wire [7:0] cmp_lo_d = wr_ol ? bus_wdata_i : compare_q[7:0];
	wire [15:0] compare_d = {cmp_hi_d, cmp_lo_d};

	// =====================================================
	// Staging register: upper writes park here, upper counter reads
	// capture the lower byte so the pair reads coherently
	wire [7:0] stage_d = (!split && (wr_ch || wr_oh)) ? bus_wdata_i :
	                     (!split && rd_ch) ? cnt_lo : stage_q;

	// =====================================================
	// Status: flags set by hardware, cleared by writing zero; set wins
	wire [7:0] stat_wmask = wr_stat ? ~bus_wdata_i : sbct_pkg::BYTE_ZERO;
	wire [7:0] flag_set;
	assign flag_set[sbct_pkg::ST_HIGH_OVF_BIT]  = ovf_h;
	assign flag_set[sbct_pkg::ST_HIGH_CMP_BIT]  = match_h;
	assign flag_set[sbct_pkg::ST_LOW_OVF_BIT]   = ovf_lo;
	assign flag_set[sbct_pkg::ST_LOW_CMP_BIT]   = match_lo;
	assign flag_set[sbct_pkg::ST_HIGH_OVIE_BIT] = 1'b0;
	assign flag_set[sbct_pkg::ST_HIGH_CCLR_BIT] = 1'b0;
	assign flag_set[sbct_pkg::ST_LOW_OVIE_BIT]  = 1'b0;
	assign flag_set[sbct_pkg::ST_LOW_CCLR_BIT]  = 1'b0;

	localparam logic [7:0] FLAG_MASK = 8'hCC;
	wire [7:0] flags_d = flag_set | (status_q & ~stat_wmask);
	wire [7:0] status_d = wr_stat ? ((flags_d & FLAG_MASK) | (bus_wdata_i & ~FLAG_MASK))
	                              : ((flags_d & FLAG_MASK) | (status_q & ~FLAG_MASK));

	// =====================================================
	// Interrupt requests: set wins over a write-one clear
	wire req_set_h = match_h || (ovf_h && ovie_h);
	wire req_set_l = match_l || (ovf_lo && ovie_l);
	wire [3:0] req_clr = wr_ireq ? bus_wdata_i[3:0] : 4'h0;
	wire [3:0] req_set = {req_set_h, req_set_l, 2'b00};
	wire [3:0] irq_req_d = req_set | (irq_req_q & ~req_clr);
	wire [3:0] irq_en_d  = wr_ien ? bus_wdata_i[3:0] : irq_en_q;

	// =====================================================
	// Toggle pins; a control write in the match cycle takes precedence
	wire pin_hi_d = wr_ctrl ? bus_wdata_i[sbct_pkg::CTL_HIGH_LEVEL_BIT] :
	                match_h ? !pin_hi_q : pin_hi_q;
	// Low pin does not toggle in cascade; only a control write loads it
	wire pin_lo_d = wr_ctrl ? bus_wdata_i[sbct_pkg::CTL_LOW_LEVEL_BIT] :
	                match_l ? !pin_lo_q : pin_lo_q;

	// =====================================================
	// Read mux; control register is write-only and reads zero
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = sbct_pkg::BYTE_ZERO;
		unique case (bus_addr_i)
			sbct_pkg::OFF_CONTROL:     rd_mux = sbct_pkg::BYTE_ZERO;
			sbct_pkg::OFF_STATUS:      rd_mux = status_q;
			sbct_pkg::OFF_COUNT_HI:    rd_mux = cnt_hi;
			sbct_pkg::OFF_COUNT_LO:    rd_mux = split ? cnt_lo : stage_q;
			sbct_pkg::OFF_COMPARE_HI:  rd_mux = compare_q[15:8];
			sbct_pkg::OFF_COMPARE_LO:  rd_mux = compare_q[7:0];
			sbct_pkg::OFF_IRQ_ENABLE:  rd_mux = {4'h0, irq_en_q};
			sbct_pkg::OFF_IRQ_REQUEST: rd_mux = {4'h0, irq_req_q};
		endcase
	end
	wire [7:0] rdata_d = (bus_rd_i && !bus_wr_i) ? rd_mux : rdata_q;

	// =====================================================
	// Registers
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_q    <= sbct_pkg::BYTE_ZERO;
			status_q  <= sbct_pkg::BYTE_ZERO;
			count_q   <= sbct_pkg::COUNT_RESET;
			compare_q <= sbct_pkg::COMPARE_RESET;
			stage_q   <= sbct_pkg::BYTE_ZERO;
			irq_en_q  <= 4'h0;
			irq_req_q <= 4'h0;
			pin_hi_q  <= 1'b0;
			pin_lo_q  <= 1'b0;
			rdata_q   <= sbct_pkg::BYTE_ZERO;
		end else begin
			ctrl_q    <= wr_ctrl ? bus_wdata_i : ctrl_q;
			status_q  <= status_d;
			count_q   <= count_d;
			compare_q <= compare_d;
			stage_q   <= stage_d;
			irq_en_q  <= irq_en_d;
			irq_req_q <= irq_req_d;
			pin_hi_q  <= pin_hi_d;
			pin_lo_q  <= pin_lo_d;
			rdata_q   <= rdata_d;
		end
	end

	// =====================================================
	// Outputs
	assign bus_rdata_o       = rdata_q;
	assign high_toggle_pin_o = pin_hi_q;
	assign low_toggle_pin_o  = pin_lo_q;
	assign high_irq_o = irq_req_q[sbct_pkg::IRQ_HIGH_BIT] & irq_en_q[sbct_pkg::IRQ_HIGH_BIT];
	assign low_irq_o  = irq_req_q[sbct_pkg::IRQ_LOW_BIT] & irq_en_q[sbct_pkg::IRQ_LOW_BIT];
endmodule : sbct_timer

// >>> tb/sbct_cpu_model.sv
// Behavioural CPU driving the timer's byte-wide register bus
module sbct_cpu_model (
	input  wire logic       core_clk_i,
	input  wire logic [7:0] bus_rdata_i,
	output logic      [2:0] bus_addr_o,
	output logic            bus_wr_o,
	output logic            bus_rd_o,
	output logic      [7:0] bus_wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		bus_addr_o  = 3'h0;
		bus_wr_o    = 1'h0;
		bus_rd_o    = 1'h0;
		bus_wdata_o = 8'h00;
	end

	// One strobe cycle; released lines show the inverse so stale values never pass
	task automatic access(input logic [2:0] addr, input logic wr, input logic [7:0] data, output logic [7:0] rdata);
		@(posedge core_clk_i);
		#5;
		bus_addr_o  = addr;
		bus_wdata_o = data;
		bus_wr_o    = wr;
		bus_rd_o    = ~wr;
		@(posedge core_clk_i);
		#5;
		rdata       = bus_rdata_i;
		bus_wr_o    = 1'h0;
		bus_rd_o    = 1'h0;
		bus_addr_o  = ~addr;
		bus_wdata_o = ~data;
	endtask : access

	task automatic wr(input logic [2:0] addr, input logic [7:0] data);
		logic [7:0] unused;
		access(addr, 1'h1, data, unused);
	endtask : wr

	task automatic rd(input logic [2:0] addr, output logic [7:0] data);
		access(addr, 1'h0, 8'h00, data);
	endtask : rd

	// Upper byte always first
	task automatic wr16(input logic [2:0] addr_hi, input logic [15:0] value);
		wr(addr_hi, value[15:8]);
		wr(addr_hi + 3'h1, value[7:0]);
	endtask : wr16

	task automatic rd16(input logic [2:0] addr_hi, output logic [15:0] value);
		rd(addr_hi, value[15:8]);
		rd(addr_hi + 3'h1, value[7:0]);
	endtask : rd16
endmodule : sbct_cpu_model

// >>> tb/sbct_timer_props.sv
// Checker for the compare timer's register bus, high pin level and interrupt gating
module sbct_timer_props (
	input wire logic       core_clk_i,
	input wire logic       reset_n_i,
	input wire logic [2:0] bus_addr_i,
	input wire logic       bus_wr_i,
	input wire logic       bus_rd_i,
	input wire logic [7:0] bus_wdata_i,
	input wire logic [7:0] bus_rdata_o,
	input wire logic       event_input_pin_i,
	input wire logic       event_rising_edge_i,
	input wire logic       subclock_i,
	input wire logic       low_power_mode_i,
	input wire logic       high_toggle_pin_o,
	input wire logic       low_toggle_pin_o,
	input wire logic       high_irq_o,
	input wire logic       low_irq_o
);
	// =====================================================
	// Shadows of write-only state; staging tracked only while known
	logic [7:0]  ctl_q;
	logic [7:0]  stage_q;
	logic [15:0] cmp_q;
	logic [1:0]  en_q;
	logic        stg_ok_q;
	logic        cmp_ok_q;
	wire         rd_go    = bus_rd_i && !bus_wr_i;
	wire         split    = ctl_q[sbct_pkg::CTL_SPLIT_BIT];
	wire         wr_ctl   = bus_wr_i && bus_addr_i == sbct_pkg::OFF_CONTROL;
	wire         wr_en    = bus_wr_i && bus_addr_i == sbct_pkg::OFF_IRQ_ENABLE;
	wire         hi_wr    = bus_wr_i && bus_addr_i == sbct_pkg::OFF_COMPARE_HI;
	wire         lo_wr    = bus_wr_i && bus_addr_i == sbct_pkg::OFF_COMPARE_LO;
	wire         any_hi   = bus_wr_i && (bus_addr_i == sbct_pkg::OFF_COUNT_HI || hi_wr);
	wire         stg_wr   = any_hi && !split;
	wire         stg_hit  = any_hi || (rd_go && bus_addr_i == sbct_pkg::OFF_COUNT_HI);
	wire         rd_cmp   = rd_go && (bus_addr_i == sbct_pkg::OFF_COMPARE_HI || bus_addr_i == sbct_pkg::OFF_COMPARE_LO);
	wire [7:0]   cmp_byte = bus_addr_i[0] ? cmp_q[7:0] : cmp_q[15:8];
	wire [15:0]  cmp_d    = split ? (hi_wr ? {bus_wdata_i, cmp_q[7:0]} : lo_wr ? {cmp_q[15:8], bus_wdata_i} : cmp_q)
	                              : (lo_wr ? {stage_q, bus_wdata_i} : cmp_q);
	wire         cmp_ok_d = (lo_wr && !split) ? stg_ok_q : cmp_ok_q;
	wire         stg_ok_d = stg_hit ? stg_wr : stg_ok_q;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctl_q    <= 8'h00;
			stage_q  <= 8'h00;
			cmp_q    <= 16'hFFFF;
			en_q     <= 2'h0;
			stg_ok_q <= 1'h0;
			cmp_ok_q <= 1'h1;
		end else begin
			ctl_q    <= wr_ctl ? bus_wdata_i : ctl_q;
			stage_q  <= stg_wr ? bus_wdata_i : stage_q;
			cmp_q    <= cmp_d;
			en_q     <= wr_en ? bus_wdata_i[3:2] : en_q;
			stg_ok_q <= stg_ok_d;
			cmp_ok_q <= cmp_ok_d;
		end
	end

	// =====================================================
	// Properties
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	rdata_hold_a: assert property (!rd_go |=> $stable(bus_rdata_o))
		else $error("read data moved without a read");
	hi_irq_gate_a: assert property (high_irq_o |-> en_q[1])
		else $error("high interrupt while disabled");
	lo_irq_gate_a: assert property (low_irq_o |-> en_q[0])
		else $error("low interrupt while disabled");
	pin_level_a: assert property (wr_ctl |=> high_toggle_pin_o == $past(bus_wdata_i[7]))
		else $error("high pin ignores written level");
	cmp_read_a: assert property ((rd_cmp && cmp_ok_q) |=> bus_rdata_o == $past(cmp_byte))
		else $error("compare byte read wrong");
	ctl_read_a: assert property (rd_go && bus_addr_i == sbct_pkg::OFF_CONTROL |=> bus_rdata_o == 8'h00)
		else $error("control read not zero");
	en_read_a: assert property (rd_go && bus_addr_i == sbct_pkg::OFF_IRQ_ENABLE |=> bus_rdata_o[3:2] == en_q)
		else $error("enable read wrong");
	reset_out_a: assert property ($rose(reset_n_i) |-> bus_rdata_o == 8'h00 && !high_irq_o && !low_irq_o)
		else $error("outputs not cleared by reset");

	cover property (wr_ctl);
	cover property ($rose(high_irq_o));
	cover property ($rose(low_irq_o));
endmodule : sbct_timer_props

bind sbct_timer sbct_timer_props u_sbct_timer_props (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i),
	.bus_rdata_o(bus_rdata_o), .event_input_pin_i(event_input_pin_i), .event_rising_edge_i(event_rising_edge_i),
	.subclock_i(subclock_i), .low_power_mode_i(low_power_mode_i), .high_toggle_pin_o(high_toggle_pin_o),
	.low_toggle_pin_o(low_toggle_pin_o), .high_irq_o(high_irq_o), .low_irq_o(low_irq_o));

// >>> tb/sbct_timer_tb.sv
// Self-checking bench for the compare timer
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
	$display("ERROR %s expected %0h seen %0h", what, exp, got); end end
module sbct_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk_i = 1'h0;
	logic        reset_n_i  = 1'h0;
	logic [2:0]  bus_addr;
	logic        bus_wr;
	logic        bus_rd;
	logic [7:0]  bus_wdata;
	logic [7:0]  bus_rdata;
	logic        event_pin  = 1'h0;
	logic        sub_clk    = 1'h0;
	logic        low_power  = 1'h0;
	logic        event_rise = 1'h1;
	logic        hi_pin;
	logic        lo_pin;
	logic        hi_irq;
	logic        lo_irq;
	logic [15:0] v16;
	logic [7:0]  v8;
	int          n_errors   = 0;
	int          checked    = 0;

	always #50 core_clk_i = ~core_clk_i;

	sbct_cpu_model u_sbct_cpu_model (.core_clk_i(core_clk_i), .bus_rdata_i(bus_rdata), .bus_addr_o(bus_addr),
		.bus_wr_o(bus_wr), .bus_rd_o(bus_rd), .bus_wdata_o(bus_wdata));
	sbct_timer u_sbct_timer (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .bus_addr_i(bus_addr),
		.bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_wdata_i(bus_wdata), .bus_rdata_o(bus_rdata),
		.event_input_pin_i(event_pin), .event_rising_edge_i(event_rise), .subclock_i(sub_clk),
		.low_power_mode_i(low_power), .high_toggle_pin_o(hi_pin), .low_toggle_pin_o(lo_pin),
		.high_irq_o(hi_irq), .low_irq_o(lo_irq));

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// Slow pulses so the pin synchronisers see every edge
	task automatic pulses(ref logic line, input int n);
		repeat (n) begin
			@(posedge core_clk_i);
			#5;
			line = 1'h1;
			repeat (6) @(posedge core_clk_i);
			#5;
			line = 1'h0;
			repeat (6) @(posedge core_clk_i);
		end
	endtask : pulses

	initial begin
		repeat (20000) @(posedge core_clk_i);
		n_errors++;
		report_and_stop();
	end

	initial begin
		repeat (4) @(posedge core_clk_i);
		#5;
		reset_n_i = 1'h1;
		u_sbct_cpu_model.rd16(sbct_pkg::OFF_COUNT_HI, v16);
		`CHK("count", 16'h0000, v16)
		u_sbct_cpu_model.rd16(sbct_pkg::OFF_COMPARE_HI, v16);
		`CHK("compare", 16'hFFFF, v16)
		u_sbct_cpu_model.rd(sbct_pkg::OFF_STATUS, v8);
		`CHK("status", 8'h00, v8)
		u_sbct_cpu_model.rd(sbct_pkg::OFF_CONTROL, v8);
		`CHK("control", 8'h00, v8)
		u_sbct_cpu_model.wr16(sbct_pkg::OFF_COUNT_HI, 16'hAA55);
		u_sbct_cpu_model.rd16(sbct_pkg::OFF_COUNT_HI, v16);
		`CHK("staged count", 16'hAA55, v16)
		u_sbct_cpu_model.wr(sbct_pkg::OFF_CONTROL, 8'h88);
		`CHK("high pin level", 1'h1, hi_pin)
		u_sbct_cpu_model.wr(sbct_pkg::OFF_CONTROL, 8'h00);
		`CHK("high pin level", 1'h0, hi_pin)
		// Compare bytes read directly, lower byte first
		u_sbct_cpu_model.wr16(sbct_pkg::OFF_COMPARE_HI, 16'h0003);
		u_sbct_cpu_model.rd(sbct_pkg::OFF_COMPARE_LO, v8);
		`CHK("compare lo", 8'h03, v8)
		u_sbct_cpu_model.rd(sbct_pkg::OFF_COMPARE_HI, v8);
		`CHK("compare hi", 8'h00, v8)
		// Full match with clear-on-match and enabled request
		u_sbct_cpu_model.wr16(sbct_pkg::OFF_COUNT_HI, 16'h0000);
		u_sbct_cpu_model.wr(sbct_pkg::OFF_STATUS, 8'h10);
		u_sbct_cpu_model.wr(sbct_pkg::OFF_IRQ_ENABLE, 8'h08);
		pulses(event_pin, 4);
		u_sbct_cpu_model.rd16(sbct_pkg::OFF_COUNT_HI, v16);
		`CHK("count after match", 16'h0000, v16)
		u_sbct_cpu_model.rd(sbct_pkg::OFF_STATUS, v8);
		`CHK("status", 8'h54, v8)
		u_sbct_cpu_model.rd(sbct_pkg::OFF_IRQ_REQUEST, v8);
		`CHK("request", 8'h08, v8)
		`CHK("high irq", 1'h1, hi_irq)
		`CHK("toggle pin", 1'h1, hi_pin)
		u_sbct_cpu_model.wr(sbct_pkg::OFF_IRQ_REQUEST, 8'h08);
		u_sbct_cpu_model.rd(sbct_pkg::OFF_IRQ_REQUEST, v8);
		`CHK("request", 8'h00, v8)
		`CHK("high irq", 1'h0, hi_irq)
		// Wrap from all ones, then latched lower byte
		u_sbct_cpu_model.wr16(sbct_pkg::OFF_COUNT_HI, 16'hFFFF);
		u_sbct_cpu_model.wr(sbct_pkg::OFF_STATUS, 8'h20);
		pulses(event_pin, 1);
		u_sbct_cpu_model.rd(sbct_pkg::OFF_STATUS, v8);
		`CHK("status", 8'hA8, v8)
		u_sbct_cpu_model.rd(sbct_pkg::OFF_IRQ_REQUEST, v8);
		`CHK("request", 8'h08, v8)
		u_sbct_cpu_model.rd(sbct_pkg::OFF_COUNT_HI, v8);
		pulses(event_pin, 1);
		u_sbct_cpu_model.rd(sbct_pkg::OFF_COUNT_LO, v8);
		`CHK("latched lo", 8'h00, v8)
		u_sbct_cpu_model.wr(sbct_pkg::OFF_IRQ_ENABLE, 8'h00);
		`CHK("high irq", 1'h0, hi_irq)
		u_sbct_cpu_model.rd(sbct_pkg::OFF_IRQ_ENABLE, v8);
		`CHK("enable", 8'h00, v8)
		// Quarter subclock, also in low-power modes
		u_sbct_cpu_model.wr(sbct_pkg::OFF_CONTROL, 8'h07);
		u_sbct_cpu_model.wr(sbct_pkg::OFF_STATUS, 8'h00);
		u_sbct_cpu_model.wr16(sbct_pkg::OFF_COUNT_HI, 16'h0000);
		pulses(sub_clk, 8);
		u_sbct_cpu_model.rd16(sbct_pkg::OFF_COUNT_HI, v16);
		`CHK("quarter count", 16'h0002, v16)
		low_power = 1'h1;
		pulses(sub_clk, 4);
		u_sbct_cpu_model.rd16(sbct_pkg::OFF_COUNT_HI, v16);
		`CHK("low power count", 16'h0003, v16)
		u_sbct_cpu_model.wr(sbct_pkg::OFF_CONTROL, 8'h06);
		repeat (100) @(posedge core_clk_i);
		u_sbct_cpu_model.rd16(sbct_pkg::OFF_COUNT_HI, v16);
		`CHK("halted count", 16'h0003, v16)
		low_power = 1'h0;
		// Split halves: lower match raises the low request
		u_sbct_cpu_model.wr(sbct_pkg::OFF_CONTROL, 8'h40);
		u_sbct_cpu_model.wr(sbct_pkg::OFF_COMPARE_LO, 8'h02);
		u_sbct_cpu_model.wr(sbct_pkg::OFF_COUNT_LO, 8'h00);
		u_sbct_cpu_model.wr(sbct_pkg::OFF_IRQ_REQUEST, 8'h0C);
		u_sbct_cpu_model.wr(sbct_pkg::OFF_IRQ_ENABLE, 8'h04);
		pulses(event_pin, 3);
		u_sbct_cpu_model.rd(sbct_pkg::OFF_STATUS, v8);
		`CHK("low match", 1'h1, v8[2])
		u_sbct_cpu_model.rd(sbct_pkg::OFF_IRQ_REQUEST, v8);
		`CHK("low request", 1'h1, v8[2])
		`CHK("low irq", 1'h1, lo_irq)
		`CHK("low toggle pin", 1'h1, lo_pin)
		u_sbct_cpu_model.wr(sbct_pkg::OFF_IRQ_REQUEST, 8'h04);
		u_sbct_cpu_model.rd(sbct_pkg::OFF_IRQ_REQUEST, v8);
		`CHK("low request", 1'h0, v8[2])
		// Falling edge select: each pulse counts once, on its trailing edge
		event_rise = 1'h0;
		pulses(event_pin, 1);
		u_sbct_cpu_model.rd(sbct_pkg::OFF_COUNT_LO, v8);
		`CHK("falling edge count", 8'h04, v8)
		report_and_stop();
	end
endmodule : sbct_timer_tb
